// >>> src/cdsc_pkg.sv
// constants for the sync-control register bank and its serial port
// Contract
// [R1] Sync functions are ignored unless master sync enable, bit 0, is high.
// [R2] The host keeps master sync low while sync is unused, to save power.
// [R3] Pulses reach the divider only while divider sync and master are high.
// [R4] With next-sync-only also high, only the first sync pulse realigns.
// [R5] In next-sync-only use, divider sync enable clears after the sync.
// [R6] After reset, data outputs stay CMOS until the host changes the type.
// [R7] A host wanting LVDS must program it, as the device never selects it.
// [R8] Data outputs are disabled while the output-disable pin is high.
// [R9] The host keeps the serial port idle while full performance is needed.
// [R10] Channel dither follows bit 4 of its dither register, off after reset.
// [R11] Incoming sync pulses are synchronised to the core clock before use.
`default_nettype none
package cdsc_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int SIG_W = 16;
  localparam logic [ADDR_W-1:0] OFF_CHAN_SEL = 13'h0005;
  localparam logic [ADDR_W-1:0] OFF_OUT_MODE = 13'h0014;
  localparam logic [ADDR_W-1:0] OFF_SIG_HIGH = 13'h0025;
  localparam logic [ADDR_W-1:0] OFF_DITHER = 13'h0030;
  localparam logic [ADDR_W-1:0] OFF_SYNC = 13'h0100;
  localparam int BIT_MASTER = 0;
  localparam int BIT_DIV_EN = 1;
  localparam int BIT_NEXT_ONLY = 2;
  localparam int BIT_DITHER = 4;
  localparam int BIT_LVDS = 6;
  localparam logic [DATA_W-1:0] SYNC_RST = 8'h00;
  localparam logic [DATA_W-1:0] SYNC_MASK = 8'h07;
  localparam logic [DATA_W-1:0] DITHER_RST = 8'h00;
  localparam logic [DATA_W-1:0] DITHER_MASK = 8'h10;
  localparam logic [DATA_W-1:0] OUT_MODE_RST = 8'h00;
  localparam logic [DATA_W-1:0] OUT_MODE_MASK = 8'h40;
  localparam logic [DATA_W-1:0] CHAN_SEL_RST = 8'h03;
  localparam logic [DATA_W-1:0] CHAN_SEL_MASK = 8'h03;
  localparam logic [4:0] INSTR_LAST = 5'h0F;
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam int INSTR_RW_POS = 14;
  typedef enum logic [1:0] {SP_IDLE, SP_INSTR, SP_DATA} cdsc_port_state_t;
endpackage
`default_nettype wire

// >>> src/cdsc_serial_port.sv
// serial configuration port slave: 16-bit instruction, then data bytes
`default_nettype none
module cdsc_serial_port import cdsc_pkg::*; (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic serialClk,
  input wire logic serialSelectLow,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  output logic [ADDR_W-1:0] regAddr,
  output logic [DATA_W-1:0] regWrData,
  output logic regWrite,
  input wire logic [DATA_W-1:0] regRdData
);
  cdsc_port_state_t state;
  logic sclkPrev;
  logic sclkRise;
  logic sclkFall;
  logic [15:0] instrShift;
  logic [DATA_W-1:0] rxShift;
  logic [DATA_W-1:0] txShift;
  logic [4:0] bitCnt;
  logic isRead;
  logic loadPending;

  assign sclkRise = serialClk && !sclkPrev;
  assign sclkFall = !serialClk && sclkPrev;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sclkPrev <= 1'b0;
    end else begin
      sclkPrev <= serialClk;
    end
  end

  // instruction and data shifting, address walk, write strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= SP_IDLE;
      instrShift <= 16'h0000;
      rxShift <= 8'h00;
      bitCnt <= 5'h00;
      isRead <= 1'b0;
      loadPending <= 1'b0;
      regAddr <= '0;
      regWrData <= 8'h00;
      regWrite <= 1'b0;
    end else begin
      regWrite <= 1'b0;
      loadPending <= 1'b0;
      if (regWrite) begin
        regAddr <= regAddr + 13'h0001;
        loadPending <= 1'b1;
      end
      if (serialSelectLow) begin
        state <= SP_IDLE;
        bitCnt <= 5'h00;
      end else begin
        case (state)
          SP_IDLE: begin
            state <= SP_INSTR;
            bitCnt <= 5'h00;
          end
          SP_INSTR: begin
            if (sclkRise) begin
              instrShift <= {instrShift[14:0], serialDataIn};
              bitCnt <= bitCnt + 5'h01;
              if (bitCnt == INSTR_LAST) begin
                state <= SP_DATA;
                bitCnt <= 5'h00;
                isRead <= instrShift[INSTR_RW_POS];
                regAddr <= {instrShift[ADDR_W-2:0], serialDataIn};
                loadPending <= 1'b1;
              end
            end
          end
          SP_DATA: begin
            if (sclkRise) begin
              rxShift <= {rxShift[6:0], serialDataIn};
              bitCnt <= bitCnt + 5'h01;
              if (bitCnt == BYTE_LAST) begin
                bitCnt <= 5'h00;
                if (isRead) begin
                  regAddr <= regAddr + 13'h0001;
                  loadPending <= 1'b1;
                end else begin
                  regWrData <= {rxShift[6:0], serialDataIn};
                  regWrite <= 1'b1;
                end
              end
            end
          end
          default: state <= SP_IDLE;
        endcase
      end
    end
  end

  // read data leaves on falling serial clock edges
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      txShift <= 8'h00;
      serialDataOut <= 1'b0;
      serialDataOe <= 1'b0;
    end else begin
      serialDataOe <= !serialSelectLow && state == SP_DATA && isRead;
      if (loadPending) begin
        txShift <= regRdData;
      end else if (sclkFall && state == SP_DATA && isRead) begin
        serialDataOut <= txShift[7];
        txShift <= {txShift[6:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/cdsc_top.sv
// sync-control, dither and output-mode register bank of the converter
`default_nettype none
module cdsc_top import cdsc_pkg::*; #(
  parameter int NUM_CH = 2
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic serialClk,
  input wire logic serialSelectLow,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  input wire logic syncIn,
  output logic dividerSync,
  input wire logic outputDisablePin,
  output logic outputLvdsMode,
  output logic outputDriveEnable,
  input wire logic [NUM_CH*SIG_W-1:0] selftestSignature,
  output logic [NUM_CH-1:0] ditherEnable
);
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData;
  logic regWrite;
  logic [DATA_W-1:0] regRdData;
  logic [DATA_W-1:0] chanSel;
  logic [DATA_W-1:0] syncCtrl;
  logic [DATA_W-1:0] outMode;
  logic [DATA_W-1:0] ditherReg [NUM_CH];
  logic [$clog2(NUM_CH)-1:0] rdChan;
  logic syncMeta;
  logic syncSafe;
  logic syncPrev;
  logic syncEdge;
  logic syncFire;
  logic syncWrite;
  logic oneShotDone;

  cdsc_serial_port uPort (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .serialClk(serialClk),
    .serialSelectLow(serialSelectLow),
    .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrite(regWrite),
    .regRdData(regRdData)
  );

  // lowest selected channel answers local reads
  always_comb begin
    rdChan = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (chanSel[i]) begin
        rdChan = i[$clog2(NUM_CH)-1:0];
      end
    end
  end

  always_comb begin
    case (regAddr)
      OFF_CHAN_SEL: regRdData = chanSel;
      OFF_OUT_MODE: regRdData = outMode;
      OFF_SIG_HIGH: regRdData = selftestSignature[rdChan*SIG_W+8 +: 8];
      OFF_DITHER: regRdData = ditherReg[rdChan];
      OFF_SYNC: regRdData = syncCtrl;
      default: regRdData = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      chanSel <= CHAN_SEL_RST;
    end else if (regWrite && regAddr == OFF_CHAN_SEL) begin
      chanSel <= regWrData & CHAN_SEL_MASK;
    end
  end

  // sync pulse synchroniser and edge detect
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      syncMeta <= 1'b0;
      syncSafe <= 1'b0;
      syncPrev <= 1'b0;
    end else begin
      syncMeta <= syncIn; // R11
      syncSafe <= syncMeta; // R11
      syncPrev <= syncSafe;
    end
  end

  assign syncEdge = syncSafe && !syncPrev;
  assign syncWrite = regWrite && regAddr == OFF_SYNC;
  assign syncFire = syncEdge && syncCtrl[BIT_MASTER] // R1
    && syncCtrl[BIT_DIV_EN]; // R3

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      syncCtrl <= SYNC_RST;
    end else if (syncWrite) begin
      syncCtrl <= regWrData & SYNC_MASK;
    end else if (syncFire && syncCtrl[BIT_NEXT_ONLY]) begin
      syncCtrl[BIT_DIV_EN] <= 1'b0; // R4 R5
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dividerSync <= 1'b0;
    end else begin
      dividerSync <= syncFire; // R3
    end
  end

  // output type and output disable
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      outMode <= OUT_MODE_RST; // R6
    end else if (regWrite && regAddr == OFF_OUT_MODE) begin
      outMode <= regWrData & OUT_MODE_MASK;
    end
  end

  assign outputLvdsMode = outMode[BIT_LVDS]; // R6

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      outputDriveEnable <= 1'b0;
    end else begin
      outputDriveEnable <= !outputDisablePin; // R8
    end
  end

  // per-channel dither registers
  for (genvar c = 0; c < NUM_CH; c++) begin : gDither
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        ditherReg[c] <= DITHER_RST; // R10
      end else if (regWrite && regAddr == OFF_DITHER && chanSel[c]) begin
        ditherReg[c] <= regWrData & DITHER_MASK;
      end
    end
    assign ditherEnable[c] = ditherReg[c][BIT_DITHER]; // R10
  end

  // one-shot spent until sync control is rewritten
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      oneShotDone <= 1'b0;
    end else if (syncWrite) begin
      oneShotDone <= 1'b0;
    end else if (syncFire && syncCtrl[BIT_NEXT_ONLY]) begin
      oneShotDone <= 1'b1;
    end
  end

  a_master_gate_sync: assert property ( // R1
    @(posedge core_clk) disable iff (sys_rst)
    dividerSync |-> $past(syncCtrl[BIT_MASTER]))
    else $error("divider sync while master enable low");

  a_continuous_sync_pass: assert property ( // R3
    @(posedge core_clk) disable iff (sys_rst)
    syncEdge && syncCtrl[BIT_MASTER] && syncCtrl[BIT_DIV_EN] |=> dividerSync)
    else $error("enabled sync pulse not passed to divider");

  a_sync_blocked_off: assert property ( // R3
    @(posedge core_clk) disable iff (sys_rst)
    syncEdge && !syncCtrl[BIT_DIV_EN] |=> !dividerSync)
    else $error("sync passed with divider sync disabled");

  a_next_only_clear: assert property ( // R5
    @(posedge core_clk) disable iff (sys_rst)
    syncFire && syncCtrl[BIT_NEXT_ONLY] && !syncWrite
      |=> !syncCtrl[BIT_DIV_EN])
    else $error("divider sync enable not cleared after one-shot");

  a_next_only_single: assert property ( // R4
    @(posedge core_clk) disable iff (sys_rst)
    oneShotDone |-> !syncFire)
    else $error("second pulse applied in one-shot mode");

  a_lvds_by_write: assert property ( // R6
    @(posedge core_clk) disable iff (sys_rst)
    $rose(outputLvdsMode) |-> $past(regWrite)
      && $past(regAddr) == OFF_OUT_MODE)
    else $error("output type changed without host write");

  a_output_disable: assert property ( // R8
    @(posedge core_clk) disable iff (sys_rst)
    outputDisablePin |=> !outputDriveEnable)
    else $error("outputs driven while disable pin high");

  a_dither_by_write: assert property ( // R10
    @(posedge core_clk) disable iff (sys_rst)
    $changed(ditherEnable) |-> $past(regWrite)
      && $past(regAddr) == OFF_DITHER)
    else $error("dither changed without host write");

  a_sync_two_stage: assert property ( // R11
    @(posedge core_clk) disable iff (sys_rst)
    syncEdge |-> $past(syncIn, 2) && !$past(syncIn, 3))
    else $error("sync edge not two stages behind input");

  a_master_off_quiet: assert property ( // R1
    @(posedge core_clk) disable iff (sys_rst)
    !syncCtrl[BIT_MASTER] |=> !dividerSync)
    else $error("divider pulse with master sync enable off");

  a_one_shot_keeps: assert property ( // R5
    @(posedge core_clk) disable iff (sys_rst)
    syncFire && syncCtrl[BIT_NEXT_ONLY] && !syncWrite
      |=> syncCtrl[BIT_MASTER] && syncCtrl[BIT_NEXT_ONLY])
    else $error("one-shot clear touched other sync bits");

  a_sync_write_wins: assert property ( // R5
    @(posedge core_clk) disable iff (sys_rst)
    syncWrite |=> syncCtrl == ($past(regWrData) & SYNC_MASK))
    else $error("host write to sync control lost");

  a_drive_follow: assert property ( // R8
    @(posedge core_clk) disable iff (sys_rst)
    !outputDisablePin |=> outputDriveEnable)
    else $error("outputs not enabled with disable pin low");
endmodule
`default_nettype wire

// >>> testbench/cdsc_host_model.sv
// host model driving the serial configuration port
`default_nettype none
module cdsc_host_model (
  input wire logic core_clk,
  output logic serialClk,
  output logic serialSelectLow,
  output logic serialDataIn,
  input wire logic serialDataOut,
  input wire logic serialDataOe,
  output logic [7:0] rdData,
  output logic rdValid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    serialClk = 1'b0;
    serialSelectLow = 1'b1; // port idle between accesses
    serialDataIn = 1'b0;
    rdData = 8'h00;
    rdValid = 1'b0;
  end
  task automatic half();
    repeat (5) @(negedge core_clk);
  endtask
  // one bit: drive, sample, rise, fall
  task automatic bit_cyc(input logic d, output logic q);
    serialDataIn = d;
    half();
    // released line reads inverted
    q = serialDataOe ? serialDataOut : ~serialDataOut;
    serialClk = 1'b1;
    half();
    serialClk = 1'b0;
  endtask
  task automatic xfer(input logic rd, input logic [12:0] a,
                      input logic [7:0] wd);
    logic [15:0] ins;
    logic q;
    ins = {rd, 2'b00, a};
    @(negedge core_clk);
    serialSelectLow = 1'b0;
    half();
    for (int i = 15; i >= 0; i--) bit_cyc(ins[i], q);
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(rd ? ~serialDataIn : wd[i], q);
      rdData[i] = q;
    end
    half();
    serialSelectLow = 1'b1;
    serialDataIn = ~serialDataIn;
    rdValid = rd;
    @(negedge core_clk);
    rdValid = 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

// >>> testbench/cdsc_top_tb.sv
// self-checking bench for the sync-control register bank
`default_nettype none
module cdsc_top_tb import cdsc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, sys_rst, serialClk, serialSelectLow, serialDataIn;
  logic serialDataOut, serialDataOe, syncIn, dividerSync;
  logic outputDisablePin, outputLvdsMode, outputDriveEnable, rdValid;
  logic [31:0] selftestSignature;
  logic [1:0] ditherEnable;
  logic [7:0] rdData, rnd;
  logic [7:0] expQ[$];
  logic [7:0] syncVal[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07};
  int syncExp[6] = '{0, 0, 0, 2, 0, 1};
  int errorCnt = 0;
  int comparisons = 0;
  int syncCnt = 0;
  int cycCnt = 0;
  int base;
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  cdsc_top #(.NUM_CH(2)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .serialClk(serialClk), .serialSelectLow(serialSelectLow),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe), .syncIn(syncIn),
    .dividerSync(dividerSync), .outputDisablePin(outputDisablePin),
    .outputLvdsMode(outputLvdsMode),
    .outputDriveEnable(outputDriveEnable),
    .selftestSignature(selftestSignature), .ditherEnable(ditherEnable));
  cdsc_host_model i_host (.core_clk(core_clk), .serialClk(serialClk),
    .serialSelectLow(serialSelectLow), .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
    .rdData(rdData), .rdValid(rdValid));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errorCnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    check(expQ.size(), 32'h00000000);
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    i_host.xfer(1'b0, a, d);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    expQ.push_back(e);
    i_host.xfer(1'b1, a, 8'h00);
  endtask
  task automatic pulse_sync(input int n);
    repeat (n) begin
      syncIn = 1'b1;
      repeat (3) @(negedge core_clk);
      syncIn = 1'b0;
      repeat (3) @(negedge core_clk);
    end
    repeat (4) @(negedge core_clk);
  endtask
  // result watcher and timeout
  always @(posedge core_clk) begin
    cycCnt <= cycCnt + 1;
    if (dividerSync === 1'b1) syncCnt <= syncCnt + 1;
    if (rdValid === 1'b1 && expQ.size() > 0) begin
      check(rdData, expQ.pop_front());
    end
    if (cycCnt == 20000) begin
      errorCnt++;
      end_sim();
    end
  end
  initial begin
    sys_rst = 1'b1;
    syncIn = 1'b0;
    outputDisablePin = 1'b1; // outputs off until LVDS set
    void'($urandom(32'h84DAFE58));
    selftestSignature = $urandom;
    repeat (16) @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    check(outputLvdsMode, 1'b0);
    check(ditherEnable, 2'b00);
    rd(OFF_SYNC, SYNC_RST);
    rd(OFF_DITHER, DITHER_RST);
    rd(OFF_SIG_HIGH, selftestSignature[15:8]);
    wr(OFF_CHAN_SEL, 8'h02);
    rd(OFF_SIG_HIGH, selftestSignature[31:24]);
    rd(13'h0050, 8'h00);
    $display("reset and readback test done");
    foreach (syncVal[k]) begin
      wr(OFF_SYNC, syncVal[k]);
      base = syncCnt;
      pulse_sync(2);
      check(syncCnt - base, syncExp[k]);
    end
    rd(OFF_SYNC, 8'h05);
    wr(OFF_SYNC, 8'h00); // sync unused, master off
    $display("sync gating test done");
    wr(OFF_CHAN_SEL, 8'h03);
    rnd = 8'($urandom);
    for (int k = 0; k < 2; k++) begin
      wr(OFF_DITHER, rnd);
      check(ditherEnable, {2{rnd[4]}});
      rd(OFF_DITHER, rnd & DITHER_MASK);
      rnd = rnd ^ 8'h10;
    end
    $display("dither test done");
    check(outputDriveEnable, 1'b0);
    wr(OFF_OUT_MODE, 8'h40);
    check(outputLvdsMode, 1'b1);
    outputDisablePin = 1'b0;
    repeat (2) @(negedge core_clk);
    check(outputDriveEnable, 1'b1);
    outputDisablePin = 1'b1;
    repeat (2) @(negedge core_clk);
    check(outputDriveEnable, 1'b0);
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    check(outputLvdsMode, 1'b0);
    $display("output mode test done");
    end_sim();
  end
endmodule
`default_nettype wire
